// File: tb/sim_monitor_properties.sv
`timescale 1ns/100ps
module sim_monitor_props
#(
  parameter int TICK_CYCLES = 10
)
(
  input wire logic            sys_clk_i,
  input wire logic            rst_i,
  input sim_pkg::sim_cfg_t    cfg_i,
  input wire logic            first_sense_channel_i,
  input wire logic            second_sense_channel_i,
  input wire logic            start_sense_input_i,
  input wire logic            first_drive_output_o,
  input wire logic            second_drive_output_o,
  input wire logic            start_drive_output_o,
  input sim_pkg::sim_status_t status_o
);
  // --------
  // Helper counters
  // --------
  localparam int W = 2 * TICK_CYCLES;
  localparam int P = 498 * TICK_CYCLES;
  localparam int F = 68 * TICK_CYCLES;
  logic [15:0] low_q, low_d, hi_q, hi_d, st_q, st_d;
  logic [15:0] rest_q, rest_d, mis_q, mis_d;
  logic        seen_q, seen_d, act_a;
  assign act_a = cfg_i.antivalent ? ~first_sense_channel_i
                                  : first_sense_channel_i;
  always_comb
  begin
    low_d  = first_drive_output_o ? 16'h0000 : low_q + 16'h0001;
    hi_d   = first_drive_output_o ? hi_q + 16'h0001 : 16'h0000;
    st_d   = start_drive_output_o ? st_q + 16'h0001 : 16'h0000;
    seen_d = seen_q | ~start_drive_output_o;
    rest_d = (!act_a && !second_sense_channel_i) ? rest_q + 16'h0001
                                                 : 16'h0000;
    mis_d  = (act_a != second_sense_channel_i) ? mis_q + 16'h0001
                                               : 16'h0000;
    if (rst_i)
      {low_d, hi_d, st_d, seen_d, rest_d, mis_d} = '0;
  end
  always_ff @(posedge sys_clk_i)
    {low_q, hi_q, st_q, seen_q, rest_q, mis_q} <=
      {low_d, hi_d, st_d, seen_d, rest_d, mis_d};
  // --------
  // Properties
  // --------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  pulse_width_a : assert property (
    $rose(first_drive_output_o) |-> low_q >= W - 1 && low_q <= W + 2)
    else $error("test pulse width off");
  pulse_period_a : assert property (
    $fell(start_drive_output_o) && seen_q |-> st_q >= P - 2 && st_q <= P + 2)
    else $error("test pulse period off");
  phase_offset_a : assert property (
    $fell(second_drive_output_o) |-> hi_q >= F - 2 && hi_q <= F + 2)
    else $error("phase offset off");
  dyn_off_a : assert property (
    !cfg_i.dyn_en |-> first_drive_output_o && second_drive_output_o)
    else $error("pulse while disabled");
  il_block_a : assert property (
    $rose(status_o.energized) |-> !status_o.interlock_alert)
    else $error("energized under interlock");
  fault_block_a : assert property (
    $rose(status_o.energized) |->
      !status_o.cross_fault && !status_o.sync_alert)
    else $error("energized under fault");
  fault_latch_a : assert property (
    status_o.cross_fault |=> status_o.cross_fault)
    else $error("cross fault dropped");
  il_rest_a : assert property (
    $fell(status_o.interlock_alert) |-> rest_q >= 999 * TICK_CYCLES - 3)
    else $error("interlock cleared early");
  sync_time_a : assert property (
    $rose(status_o.sync_alert) |->
      mis_q >= 99 * TICK_CYCLES - 3 && mis_q <= 101 * TICK_CYCLES + 3)
    else $error("sync alert timing off");
endmodule
bind sim_safety_input_monitor sim_monitor_props
  #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_i(cfg_i),
  .first_sense_channel_i(first_sense_channel_i),
  .second_sense_channel_i(second_sense_channel_i),
  .start_sense_input_i(start_sense_input_i),
  .first_drive_output_o(first_drive_output_o),
  .second_drive_output_o(second_drive_output_o),
  .start_drive_output_o(start_drive_output_o), .status_o(status_o));

// File: tb/sim_sensor_model.sv
`timescale 1ns/100ps
module sim_sensor_model
(
  input wire logic       first_drive_i,
  input wire logic       second_drive_i,
  input wire logic       start_drive_i,
  input wire logic [2:0] closed_i,
  input wire logic [1:0] mode_i,
  output logic           first_sense_o,
  output logic           second_sense_o,
  output logic           start_sense_o
);
  // --------
  // Contacts; an open one leaves its line to the pull-down
  // --------
  always_comb
  begin
    case (mode_i)
      2'h1:    first_sense_o = closed_i[0] & second_drive_i;
      2'h2:    first_sense_o = closed_i[0];
      default: first_sense_o = closed_i[0] & first_drive_i;
    endcase
    second_sense_o = closed_i[1] & second_drive_i;
    start_sense_o  = closed_i[2] & start_drive_i;
  end
endmodule

// File: tb/test_safety_input_monitor.sv
`timescale 1ns/100ps
module test_safety_input_monitor;
  localparam int TC = 10;
  logic                 sys_clk_i, rst_i, fs, ss, ts, fd, sd, td;
  sim_pkg::sim_cfg_t    cfg;
  sim_pkg::sim_status_t st;
  logic [2:0]           closed;
  logic [1:0]           mode;
  int                   n_errors, tests_run, n, nf, ns, nt;
  sim_safety_input_monitor #(.TICK_CYCLES(TC)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_i(cfg),
    .first_sense_channel_i(fs), .second_sense_channel_i(ss),
    .start_sense_input_i(ts), .first_drive_output_o(fd),
    .second_drive_output_o(sd), .start_drive_output_o(td),
    .status_o(st));
  sim_sensor_model i_model (
    .first_drive_i(fd), .second_drive_i(sd), .start_drive_i(td),
    .closed_i(closed), .mode_i(mode), .first_sense_o(fs),
    .second_sense_o(ss), .start_sense_o(ts));
  // --------
  // Tasks
  // --------
  function automatic logic act_pair(input logic anti, input logic [2:0] k);
    return (anti ? ~k[0] : k[0]) & k[1];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic restart(input logic [3:0] c, input logic [2:0] k);
    rst_i = 1'b1;
    cfg = c;
    closed = k;
    mode = 2'h0;
    step(10);
    rst_i = 1'b0;
  endtask
  task automatic wait_st(input int idx, input int lim, output int cyc);
    cyc = 0;
    while (st[idx] !== 1'b1 && cyc < lim)
    begin
      step(1);
      cyc++;
    end
    if (cyc >= lim)
    begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic count_falls(input int c);
    logic pf, ps, pt;
    nf = 0;
    ns = 0;
    nt = 0;
    repeat (c)
    begin
      pf = fd;
      ps = sd;
      pt = td;
      step(1);
      if (pf && !fd) nf++;
      if (ps && !sd) ns++;
      if (pt && !td) nt++;
    end
  endtask
  task automatic energize(input logic [3:0] c);
    restart(c, 3'h4);
    step(2);
    closed = 3'h7;
    step(10);
    check(st.energized, 16'(act_pair(c[0], 3'h7)));
  endtask
  // --------
  // Stimulus
  // --------
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    rst_i = 1'b1;
    cfg = 4'h0;
    closed = 3'h0;
    mode = 2'h0;
    n_errors = 0;
    tests_run = 0;
    void'($urandom(78));
    restart(4'h4, 3'h4);
    step(5);
    closed = 3'h7;
    step(600);
    check(st.energized, 16'h0001);
    count_falls(500 * TC);
    check(16'(nf), 16'h0001);
    check(16'(ns), 16'h0001);
    check(16'(nt), 16'h0001);
    check(st.cross_fault, 16'h0000);
    restart(4'h0, 3'h7);
    count_falls(500 * TC);
    check(16'(nf + ns), 16'h0000);
    check(16'(nt), 16'h0001);
    for (int m = 1; m <= 2; m++)
    begin
      restart(4'h4, 3'h7);
      mode = 2'(m);
      wait_st(0, 600 * TC, n);
      check(st.energized, 16'h0000);
    end
    energize(4'h2);
    step($urandom_range(50, 0));
    closed = 3'h6;
    wait_st(2, 210 * TC, n);
    check(n >= 199 * TC && n <= 201 * TC + 4, 16'h0001);
    check(st.energized, 16'h0000);
    closed = 3'h7;
    step(30);
    check(st.energized, 16'h0000);
    closed = 3'h4;
    step(990 * TC);
    check(st.interlock_alert, 16'h0001);
    step(20 * TC);
    closed = 3'h7;
    step(10);
    check(st.energized, 16'h0001);
    repeat (3)
    begin
      energize(4'h2);
      closed = 3'h6;
      step($urandom_range(180, 1) * TC);
      closed = 3'h4;
      step(300 * TC);
      check(st.interlock_alert, 16'h0000);
      closed = 3'h7;
      step(10);
      check(st.energized, 16'h0001);
      closed = 3'h6;
      step($urandom_range(150, 10) * TC);
      closed = 3'h7;
      wait_st(2, 5, n);
      check(st.energized, 16'h0000);
    end
    restart(4'h9, 3'h5);
    step(2);
    closed = 3'h6;
    step(10);
    check(st.energized, 16'(act_pair(1'b1, 3'h6)));
    closed = 3'h4;
    step(95 * TC);
    check(st.sync_alert, 16'h0000);
    step(7 * TC);
    check(st.sync_alert, 16'h0001);
    closed = 3'h6;
    step(10);
    check(st.energized, 16'h0000);
    print_verdict();
  end
endmodule

// File: verilog/sim_dyn_channel.sv
`timescale 1ns/100ps
module sim_dyn_channel
(
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     tick_i,
  input  wire logic                     enable_i,
  input  wire logic [sim_pkg::MS_W-1:0] pos_i,
  input  wire logic                     sense_i,
  output logic                          drive_o,
  output logic                          busy_o,
  output logic                          fault_o
);

  // ----------------------------------------------------------------
  // Pulse generation and return check
  // ----------------------------------------------------------------
  logic                     drive_d, busy_d, fault_d;
  logic                     armed_q, armed_d, seen_q, seen_d;
  logic                     prev_q, prev_d, away_q, away_d;
  logic [sim_pkg::MS_W-1:0] away_cnt_q, away_cnt_d;

  always_comb
  begin
    drive_d    = ~(enable_i && pos_i < sim_pkg::TEST_PULSE_WIDTH);
    busy_d     = enable_i && pos_i < sim_pkg::TEST_PULSE_RETURN_WINDOW
                 + sim_pkg::TEST_PULSE_WIDTH;
    fault_d    = fault_o;
    armed_d    = armed_q;
    seen_d     = seen_q;
    prev_d     = sense_i;
    away_d     = away_q;
    away_cnt_d = away_cnt_q;
    if (tick_i && enable_i && pos_i == sim_pkg::MS_RST)
    begin
      armed_d = sense_i;
      seen_d  = 1'b0;
    end
    else if (armed_q && !sense_i && busy_o)
      seen_d = 1'b1;
    if (tick_i && enable_i && armed_q && !seen_d
        && pos_i == sim_pkg::TEST_PULSE_RETURN_WINDOW)
    begin
      fault_d = 1'b1;
      armed_d = 1'b0;
    end
    if (busy_o)
      away_d = 1'b0;
    else if (prev_q && !sense_i)
    begin
      away_d     = 1'b1;
      away_cnt_d = sim_pkg::MS_RST;
    end
    else if (away_q && sense_i)
    begin
      away_d = 1'b0;
      if (away_cnt_q <= sim_pkg::TEST_PULSE_WIDTH)
        fault_d = 1'b1;
    end
    else if (away_q && tick_i)
      away_cnt_d = sim_pkg::sim_sat_inc(away_cnt_q);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      drive_o    <= 1'b1;
      busy_o     <= 1'b0;
      fault_o    <= 1'b0;
      armed_q    <= 1'b0;
      seen_q     <= 1'b0;
      prev_q     <= 1'b0;
      away_q     <= 1'b0;
      away_cnt_q <= sim_pkg::MS_RST;
    end
    else
    begin
      drive_o    <= drive_d;
      busy_o     <= busy_d;
      fault_o    <= fault_d;
      armed_q    <= armed_d;
      seen_q     <= seen_d;
      prev_q     <= prev_d;
      away_q     <= away_d;
      away_cnt_q <= away_cnt_d;
    end
  end

endmodule

// File: verilog/sim_pkg.sv
package sim_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_MS       = 1;
  localparam int TICK_W        = 17;
  localparam int MS_W          = 11;

  // ----------------------------------------------------------------
  // Times in milliseconds
  // ----------------------------------------------------------------
  localparam int TEST_PULSE_WIDTH_MS         = 2;
  localparam int TEST_PULSE_PERIOD_MS        = 500;
  localparam int TEST_PULSE_RETURN_WINDOW_MS = 40;
  localparam int TEST_PULSE_PHASE_OFFSET_MS  = 70;
  localparam int INTERLOCK_MS                = 200;
  localparam int REST_MS                     = 1000;
  localparam int SYNC_MS                     = 100;

  // ----------------------------------------------------------------
  // Times in ticks
  // ----------------------------------------------------------------
  localparam logic [MS_W-1:0] TEST_PULSE_WIDTH =
    MS_W'(TEST_PULSE_WIDTH_MS / TICK_MS);
  localparam logic [MS_W-1:0] TEST_PULSE_PERIOD =
    MS_W'(TEST_PULSE_PERIOD_MS / TICK_MS);
  localparam logic [MS_W-1:0] TEST_PULSE_RETURN_WINDOW =
    MS_W'(TEST_PULSE_RETURN_WINDOW_MS / TICK_MS);
  localparam logic [MS_W-1:0] TEST_PULSE_PHASE_OFFSET =
    MS_W'(TEST_PULSE_PHASE_OFFSET_MS / TICK_MS);
  localparam logic [MS_W-1:0] INTERLOCK_TICKS =
    MS_W'(INTERLOCK_MS / TICK_MS);
  localparam logic [MS_W-1:0] REST_TICKS  = MS_W'(REST_MS / TICK_MS);
  localparam logic [MS_W-1:0] SYNC_TICKS  = MS_W'(SYNC_MS / TICK_MS);

  // ----------------------------------------------------------------
  // Phase of each drive output within the pulse period
  // ----------------------------------------------------------------
  localparam logic [MS_W-1:0] PHASE_FIRST  = 11'h000;
  localparam logic [MS_W-1:0] PHASE_SECOND = TEST_PULSE_PHASE_OFFSET;
  localparam logic [MS_W-1:0] PHASE_START  =
    MS_W'(2 * TEST_PULSE_PHASE_OFFSET_MS / TICK_MS);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [MS_W-1:0]   MS_RST   = 11'h000;
  localparam logic [TICK_W-1:0] TICK_RST = 17'h00000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync_en;
    logic dyn_en;
    logic interlock_en;
    logic antivalent;
  } sim_cfg_t;

  typedef struct packed {
    logic energized;
    logic interlock_alert;
    logic sync_alert;
    logic cross_fault;
  } sim_status_t;

  localparam sim_status_t STATUS_RST = 4'h0;

  typedef enum logic [1:0] {
    IL_WATCH,
    IL_TIMING,
    IL_LOCKED
  } sim_il_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [MS_W-1:0] sim_phase_pos(
    input logic [MS_W-1:0] pos,
    input logic [MS_W-1:0] phase
  );
    logic [MS_W:0] sum;
    sum = {1'b0, pos} + {1'b0, TEST_PULSE_PERIOD} - {1'b0, phase};
    if (sum >= {1'b0, TEST_PULSE_PERIOD})
      sum = sum - {1'b0, TEST_PULSE_PERIOD};
    return sum[MS_W-1:0];
  endfunction

  function automatic logic [MS_W-1:0] sim_sat_inc(
    input logic [MS_W-1:0] v
  );
    return (v == {MS_W{1'b1}}) ? v : v + 11'h001;
  endfunction

endpackage

// File: verilog/sim_safety_input_monitor.sv
`timescale 1ns/100ps
module sim_safety_input_monitor
#(
  parameter int TICK_CYCLES = sim_pkg::TICK_CYCLES
)
(
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  input  sim_pkg::sim_cfg_t  cfg_i,
  input  wire logic          first_sense_channel_i,
  input  wire logic          second_sense_channel_i,
  input  wire logic          start_sense_input_i,
  output logic               first_drive_output_o,
  output logic               second_drive_output_o,
  output logic               start_drive_output_o,
  output sim_pkg::sim_status_t status_o
);

  // ----------------------------------------------------------------
  // Millisecond tick and pulse period position
  // ----------------------------------------------------------------
  logic [sim_pkg::TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic                       tick_q, tick_d;
  logic [sim_pkg::MS_W-1:0]   pos_q, pos_d;

  always_comb
  begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 17'h00001;
    pos_d      = pos_q;
    if (tick_cnt_q == sim_pkg::TICK_W'(TICK_CYCLES - 1))
    begin
      tick_cnt_d = sim_pkg::TICK_RST;
      tick_d     = 1'b1;
    end
    if (tick_q)
    begin
      if (pos_q == sim_pkg::TEST_PULSE_PERIOD - 11'h001)
        pos_d = sim_pkg::MS_RST;
      else
        pos_d = pos_q + 11'h001;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt_q <= sim_pkg::TICK_RST;
      tick_q     <= 1'b0;
      pos_q      <= sim_pkg::MS_RST;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
      pos_q      <= pos_d;
    end
  end

  // ----------------------------------------------------------------
  // Test pulse channels
  // ----------------------------------------------------------------
  logic busy_first, busy_second, fault_first, fault_second, fault_start;

  sim_dyn_channel u_first
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick_q),
    .enable_i  (cfg_i.dyn_en),
    .pos_i     (sim_pkg::sim_phase_pos(pos_q, sim_pkg::PHASE_FIRST)),
    .sense_i   (first_sense_channel_i),
    .drive_o   (first_drive_output_o),
    .busy_o    (busy_first),
    .fault_o   (fault_first)
  );

  sim_dyn_channel u_second
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick_q),
    .enable_i  (cfg_i.dyn_en),
    .pos_i     (sim_pkg::sim_phase_pos(pos_q, sim_pkg::PHASE_SECOND)),
    .sense_i   (second_sense_channel_i),
    .drive_o   (second_drive_output_o),
    .busy_o    (busy_second),
    .fault_o   (fault_second)
  );

  sim_dyn_channel u_start
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick_q),
    .enable_i  (1'b1),
    .pos_i     (sim_pkg::sim_phase_pos(pos_q, sim_pkg::PHASE_START)),
    .sense_i   (start_sense_input_i),
    .drive_o   (start_drive_output_o),
    .busy_o    (),
    .fault_o   (fault_start)
  );

  // ----------------------------------------------------------------
  // Channel levels, held while a channel's own test pulse and its return window run
  // ----------------------------------------------------------------
  logic a_q, a_d, b_q, b_d;

  always_comb
  begin
    a_d = a_q;
    b_d = b_q;
    if (!busy_first)
      a_d = cfg_i.antivalent ? ~first_sense_channel_i
                             : first_sense_channel_i;
    if (!busy_second)
      b_d = second_sense_channel_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  // ----------------------------------------------------------------
  // Synchronization supervision
  // ----------------------------------------------------------------
  logic [sim_pkg::MS_W-1:0] mis_cnt_q, mis_cnt_d;
  logic                     sync_alert_q, sync_alert_d;

  always_comb
  begin
    mis_cnt_d    = mis_cnt_q;
    sync_alert_d = sync_alert_q;
    if (!cfg_i.sync_en || a_q == b_q)
      mis_cnt_d = sim_pkg::MS_RST;
    else if (tick_q)
      mis_cnt_d = sim_pkg::sim_sat_inc(mis_cnt_q);
    if (!a_q && !b_q)
      sync_alert_d = 1'b0;
    if (mis_cnt_q >= sim_pkg::SYNC_TICKS)
      sync_alert_d = 1'b1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      mis_cnt_q    <= sim_pkg::MS_RST;
      sync_alert_q <= 1'b0;
    end
    else
    begin
      mis_cnt_q    <= mis_cnt_d;
      sync_alert_q <= sync_alert_d;
    end
  end

  // ----------------------------------------------------------------
  // Signal interlock supervision
  // ----------------------------------------------------------------
  sim_pkg::sim_il_state_t   il_q, il_d;
  logic [sim_pkg::MS_W-1:0] il_cnt_q, il_cnt_d;
  logic                     lead_a_q, lead_a_d;
  logic                     lead_on, other_on;

  always_comb
  begin
    il_d     = il_q;
    il_cnt_d = il_cnt_q;
    lead_a_d = lead_a_q;
    lead_on  = lead_a_q ? a_q : b_q;
    other_on = lead_a_q ? b_q : a_q;
    case (il_q)
      sim_pkg::IL_WATCH:
      begin
        il_cnt_d = sim_pkg::MS_RST;
        if (cfg_i.interlock_en && (a_q ^ b_q) && status_o.energized)
        begin
          il_d     = sim_pkg::IL_TIMING;
          lead_a_d = ~a_q;
        end
      end
      sim_pkg::IL_TIMING:
      begin
        if (tick_q)
          il_cnt_d = sim_pkg::sim_sat_inc(il_cnt_q);
        if (!other_on && !lead_on)
          il_d = sim_pkg::IL_WATCH;
        else if (lead_on)
        begin
          il_d     = sim_pkg::IL_LOCKED;
          il_cnt_d = sim_pkg::MS_RST;
        end
        else if (il_cnt_q >= sim_pkg::INTERLOCK_TICKS)
        begin
          il_d     = sim_pkg::IL_LOCKED;
          il_cnt_d = sim_pkg::MS_RST;
        end
      end
      sim_pkg::IL_LOCKED:
      begin
        if (a_q || b_q)
          il_cnt_d = sim_pkg::MS_RST;
        else if (tick_q)
          il_cnt_d = sim_pkg::sim_sat_inc(il_cnt_q);
        if (il_cnt_q >= sim_pkg::REST_TICKS)
          il_d = sim_pkg::IL_WATCH;
      end
      default:
        il_d = sim_pkg::IL_LOCKED;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      il_q     <= sim_pkg::IL_WATCH;
      il_cnt_q <= sim_pkg::MS_RST;
      lead_a_q <= 1'b0;
    end
    else
    begin
      il_q     <= il_d;
      il_cnt_q <= il_cnt_d;
      lead_a_q <= lead_a_d;
    end
  end

  // ----------------------------------------------------------------
  // Output state and status
  // ----------------------------------------------------------------
  sim_pkg::sim_status_t status_d;

  always_comb
  begin
    status_d                 = status_o;
    status_d.interlock_alert = (il_d == sim_pkg::IL_LOCKED);
    status_d.sync_alert      = sync_alert_q;
    status_d.cross_fault     = status_o.cross_fault | fault_first
                               | fault_second | fault_start;
    status_d.energized       = a_q && b_q
                               && il_d != sim_pkg::IL_LOCKED
                               && !sync_alert_q
                               && !status_d.cross_fault;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      status_o <= sim_pkg::STATUS_RST;
    else
      status_o <= status_d;
  end

endmodule
